// ---- hdl/uhbpi_consts.vh ----
`ifndef UHBPI_CONSTS_VH
`define UHBPI_CONSTS_VH

// Host bus widths
`define UHBPI_DATA_W        8
`define UHBPI_ADDR_W        3

// Bus style select pin levels
`define UHBPI_STYLE_STROBE  1'h1
`define UHBPI_STYLE_RWLINE  1'h0

// Direction line levels in read/write-line style
`define UHBPI_RW_READ       1'h1
`define UHBPI_RW_WRITE      1'h0

// Serial line idle levels
`define UHBPI_TX_IDLE_STD   1'h1
`define UHBPI_TX_IDLE_IR    1'h0

// Synchronised pin bundle layout
`define UHBPI_SYNC_W        17
`define UHBPI_SP_DATA_LO    0
`define UHBPI_SP_ADDR_LO    8
`define UHBPI_SP_STYLE      11
`define UHBPI_SP_CS_N       12
`define UHBPI_SP_RD_N       13
`define UHBPI_SP_WR_N       14
`define UHBPI_SP_RX         15
`define UHBPI_SP_SPARE      16
`define UHBPI_SYNC_INIT     17'h0f800

// Access sequencer states
`define UHBPI_ST_IDLE       2'h0
`define UHBPI_ST_READ       2'h1
`define UHBPI_ST_WRITE      2'h2

`endif

// ---- hdl/uhbpi_sync.v ----
`timescale 1ns/100ps
`default_nettype none

module uhbpi_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input  wire             clk,
  input  wire             rst,
  input  wire             clkEn,
  input  wire [WIDTH-1:0] asyncIn,
  output reg  [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stage1;

  // First stage is read only by the second stage
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1  <= INIT;
      syncOut <= INIT;
    end else if (clkEn) begin
      stage1  <= asyncIn;
      syncOut <= stage1;
    end
  end

endmodule

`default_nettype wire

// ---- hdl/uhbpi_host_port.v ----
// Summary of operation
// - Strobe style: read strobe fall reads addressed register; host samples at rise.
// - Read/write-line style ignores the read strobe pin completely.
// - Strobe style: write strobe rise stores bus byte into addressed register.
// - Read/write-line style: write strobe pin is direction, high read, low write.
// - Bus accesses are honoured only while chip select is held low.
// - Strobe style: interrupt active high, driven only when output enable bit set.
// - Read/write-line style: interrupt active low open drain, never driven high.
// - Standard mode: transmit rests high during reset and idle.
// - Infrared mode: transmit and receive are plainly inverted; transmit rests low when idle.
// - Eight-bit bidirectional data bus; host drives writes, device drives reads.
// - Three address lines select the internal register accessed.
`timescale 1ns/100ps
`default_nettype none
`include "uhbpi_consts.vh"

module uhbpi_host_port (
  input  wire                        clk,
  input  wire                        rst,
  input  wire                        clkEn,
  // Host side pins
  input  wire                        busStyleSel,
  input  wire                        chipSelN,
  input  wire                        readStrobeN,
  input  wire                        writeStrobeN,
  input  wire [`UHBPI_ADDR_W-1:0]    registerSelectLines,
  input  wire [`UHBPI_DATA_W-1:0]    hostDataLinesIn,
  output reg  [`UHBPI_DATA_W-1:0]    hostDataLinesOut,
  output reg                         hostDataLinesOeN,
  output reg                         irqOut,
  output reg                         irqOeN,
  // Serial pins
  output reg                         txPin,
  input  wire                        rxPin,
  // Internal register file side
  output reg                         regRead,
  output reg                         regWrite,
  output reg  [`UHBPI_ADDR_W-1:0]    regAddr,
  output reg  [`UHBPI_DATA_W-1:0]    regWrData,
  input  wire [`UHBPI_DATA_W-1:0]    regRdData,
  input  wire                        intRequest,
  input  wire                        irq_output_enable_bit,
  input  wire                        infrared_mode_bit,
  // Serial engine side
  input  wire                        txSerial,
  input  wire                        txActive,
  output reg                         rxSerial
);

  wire [`UHBPI_SYNC_W-1:0] pinsRaw;
  wire [`UHBPI_SYNC_W-1:0] pinsSync;

  assign pinsRaw = {1'b0, rxPin, writeStrobeN, readStrobeN, chipSelN, busStyleSel,
                    registerSelectLines, hostDataLinesIn};

  // Strobes and selects idle high so no false access leaves reset
  uhbpi_sync #(
    .WIDTH (`UHBPI_SYNC_W),
    .INIT  (`UHBPI_SYNC_INIT)
  ) pinSync (
    .clk     (clk),
    .rst     (rst),
    .clkEn   (clkEn),
    .asyncIn (pinsRaw),
    .syncOut (pinsSync)
  );

  wire [`UHBPI_DATA_W-1:0] sData  = pinsSync[`UHBPI_SP_DATA_LO +: `UHBPI_DATA_W];
  wire [`UHBPI_ADDR_W-1:0] sAddr  = pinsSync[`UHBPI_SP_ADDR_LO +: `UHBPI_ADDR_W];
  wire                     sStyle = pinsSync[`UHBPI_SP_STYLE];
  wire                     sCsN   = pinsSync[`UHBPI_SP_CS_N];
  wire                     sRdN   = pinsSync[`UHBPI_SP_RD_N];
  wire                     sWrN   = pinsSync[`UHBPI_SP_WR_N];
  wire                     sRx    = pinsSync[`UHBPI_SP_RX];

  // Previous synchronised levels for edge detection
  reg prevCsN;
  reg prevRdN;
  reg prevWrN;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      prevCsN <= 1'h1;
      prevRdN <= 1'h1;
      prevWrN <= 1'h1;
    end else if (clkEn) begin
      prevCsN <= sCsN;
      prevRdN <= sRdN;
      prevWrN <= sWrN;
    end
  end

  function edgeFall;
    input prevLevel;
    input nowLevel;
    begin
      edgeFall = prevLevel & ~nowLevel;
    end
  endfunction

  wire strobeStyle = (sStyle == `UHBPI_STYLE_STROBE);
  wire selected    = ~sCsN;

  // Strobe style: strobes qualified by chip select; read strobe unused otherwise
  wire stRdStart = strobeStyle & selected & edgeFall(prevRdN, sRdN);
  wire stRdEnd   = ~edgeFall(sRdN, prevRdN) ? sRdN | sCsN : 1'h1;
  wire stWrStart = strobeStyle & selected & edgeFall(prevWrN, sWrN);
  wire stWrEnd   = edgeFall(sWrN, prevWrN) | sCsN;

  // Read/write-line style: chip select framing, direction on write strobe pin
  wire csFall    = edgeFall(prevCsN, sCsN);
  wire csRise    = edgeFall(sCsN, prevCsN);
  wire rwRdStart = ~strobeStyle & csFall & (sWrN == `UHBPI_RW_READ);
  wire rwWrStart = ~strobeStyle & csFall & (sWrN == `UHBPI_RW_WRITE);

  localparam [1:0] ST_IDLE  = `UHBPI_ST_IDLE;
  localparam [1:0] ST_READ  = `UHBPI_ST_READ;
  localparam [1:0] ST_WRITE = `UHBPI_ST_WRITE;

  reg [1:0]                state;
  reg [1:0]                next_state;
  reg                      accStyle;
  reg [`UHBPI_ADDR_W-1:0]  accAddr;

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (stRdStart | rwRdStart) begin
          next_state = ST_READ;
        end else if (stWrStart | rwWrStart) begin
          next_state = ST_WRITE;
        end
      end
      ST_READ: begin
        if (accStyle == `UHBPI_STYLE_STROBE) begin
          if (stRdEnd) begin
            next_state = ST_IDLE;
          end
        end else if (sCsN) begin
          next_state = ST_IDLE;
        end
      end
      ST_WRITE: begin
        if (accStyle == `UHBPI_STYLE_STROBE) begin
          if (stWrEnd) begin
            next_state = ST_IDLE;
          end
        end else if (sCsN) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Write commits on the closing edge; data is latched then, not at the start
  wire wrCommit = (state == ST_WRITE) &
                  (((accStyle == `UHBPI_STYLE_STROBE) & edgeFall(sWrN, prevWrN) & selected) |
                   ((accStyle == `UHBPI_STYLE_RWLINE) & csRise));

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state     <= ST_IDLE;
      accStyle  <= `UHBPI_STYLE_STROBE;
      accAddr   <= 3'h0;
      regRead   <= 1'h0;
      regWrite  <= 1'h0;
      regAddr   <= 3'h0;
      regWrData <= 8'h00;
    end else if (clkEn) begin
      state    <= next_state;
      regRead  <= 1'h0;
      regWrite <= 1'h0;
      if (state == ST_IDLE) begin
        accStyle <= sStyle;
        accAddr  <= sAddr;
      end
      if ((state == ST_IDLE) & (stRdStart | rwRdStart)) begin
        regRead <= 1'h1;
        regAddr <= sAddr;
      end
      if (wrCommit) begin
        regWrite  <= 1'h1;
        regAddr   <= accAddr;
        regWrData <= sData;
      end
    end
  end

  // Read data captured the cycle after the read pulse, then driven until release
  reg readPending;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      readPending      <= 1'h0;
      hostDataLinesOut <= 8'h00;
      hostDataLinesOeN <= 1'h1;
    end else if (clkEn) begin
      readPending <= regRead;
      if (readPending) begin
        hostDataLinesOut <= regRdData;
      end
      // Drive only inside a read; released otherwise to avoid contention
      hostDataLinesOeN <= ~((state == ST_READ) & (next_state == ST_READ) &
                            ~regRead);
    end
  end

  // Interrupt pin shaping per bus style
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      irqOut <= 1'h0;
      irqOeN <= 1'h1;
    end else if (clkEn) begin
      if (strobeStyle) begin
        irqOut <= intRequest;
        irqOeN <= ~irq_output_enable_bit;
      end else begin
        irqOut <= 1'h0;
        irqOeN <= ~intRequest;
      end
    end
  end

  // Serial line: plain inversion in infrared mode, one flop to the pin
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      txPin    <= `UHBPI_TX_IDLE_STD;
      rxSerial <= 1'h1;
    end else if (clkEn) begin
      if (infrared_mode_bit) begin
        txPin    <= txActive ? ~txSerial : `UHBPI_TX_IDLE_IR;
        rxSerial <= ~sRx;
      end else begin
        txPin    <= txActive ? txSerial : `UHBPI_TX_IDLE_STD;
        rxSerial <= sRx;
      end
    end
  end

endmodule

`default_nettype wire

// ---- testbench/uhbpi_reg_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module uhbpi_reg_model (
  input  wire logic       clk,
  input  wire logic       regWrite,
  input  wire logic [2:0] regAddr,
  input  wire logic [7:0] regWrData,
  output var  logic [7:0] regRdData
);
  logic [7:0] mem [8];

  // Combinational read so the capture edge choice cannot skew data
  assign regRdData = mem[regAddr];

  always @(posedge clk) begin
    if (regWrite) begin
      mem[regAddr] <= regWrData;
    end
  end
endmodule

`default_nettype wire

// ---- testbench/uhbpi_host_port_props.sv ----
`timescale 1ns/100ps
`default_nettype none

module uhbpi_host_port_props (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       busStyleSel,
  input wire logic       chipSelN,
  input wire logic [7:0] hostDataLinesOut,
  input wire logic       hostDataLinesOeN,
  input wire logic       irqOut,
  input wire logic       irqOeN,
  input wire logic       txPin,
  input wire logic       regRead,
  input wire logic       regWrite,
  input wire logic [7:0] regRdData,
  input wire logic       intRequest,
  input wire logic       irq_output_enable_bit,
  input wire logic       infrared_mode_bit,
  input wire logic       txActive,
  input wire logic       txSerial,
  input wire logic       rxPin,
  input wire logic       rxSerial
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  read_pulse_a: assert property (regRead |=> !regRead) else $error("read pulse too long");
  write_pulse_a: assert property (regWrite |=> !regWrite) else $error("write pulse long");
  read_drive_a: assert property (regRead |-> ##2
    (!hostDataLinesOeN && hostDataLinesOut == $past(regRdData))) else $error("read data bad");
  bus_release_a: assert property ($rose(chipSelN) |-> ##[1:4] hostDataLinesOeN)
    else $error("bus not released");
  write_nodrive_a: assert property (regWrite |-> hostDataLinesOeN) else $error("drive in write");
  irq_strobe_a: assert property (busStyleSel[*4] |=>
    (irqOut == $past(intRequest) && irqOeN == !$past(irq_output_enable_bit)))
    else $error("strobe irq wrong");
  irq_drain_a: assert property ((!busStyleSel)[*4] |=>
    (!irqOut && irqOeN == !$past(intRequest))) else $error("open drain irq wrong");
  tx_idle_std_a: assert property ((!txActive && !infrared_mode_bit) |=> txPin)
    else $error("tx idle not high");
  tx_idle_ir_a: assert property ((!txActive && infrared_mode_bit) |=> !txPin)
    else $error("tx idle not low");
  tx_data_a: assert property (txActive |=>
    (txPin == ($past(infrared_mode_bit) ? !$past(txSerial) : $past(txSerial))))
    else $error("tx data wrong");
  rx_path_a: assert property (rxSerial ==
    ($past(infrared_mode_bit) ? !$past(rxPin, 3) : $past(rxPin, 3)))
    else $error("rx path wrong");
endmodule

bind uhbpi_host_port uhbpi_host_port_props uhbpi_host_port_props_inst (.clk, .rst,
  .busStyleSel, .chipSelN, .hostDataLinesOut, .hostDataLinesOeN, .irqOut, .irqOeN, .txPin,
  .regRead, .regWrite, .regRdData, .intRequest, .irq_output_enable_bit, .infrared_mode_bit,
  .txActive, .txSerial, .rxPin, .rxSerial);

`default_nettype wire

// ---- testbench/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic clk = 0, rst = 1, busStyleSel = 1, chipSelN = 1, readStrobeN = 1, writeStrobeN = 1;
  logic intRequest = 0, irq_output_enable_bit = 0, infrared_mode_bit = 0;
  logic txSerial = 0, txActive = 0, rxPin = 1, oePrev = 1;
  logic [6:0] rnd;
  logic [2:0] registerSelectLines = 0, rdA = 0, regAddr;
  logic [7:0] hostDataLinesIn = 0, hostDataLinesOut, regWrData, regRdData;
  logic [7:0] shadow [8];
  logic hostDataLinesOeN, irqOut, irqOeN, txPin, regRead, regWrite, rxSerial;
  logic [11:0] q [$];
  int seed = 47142, miscompares = 0, checks_done = 0, cyc = 0, i;

  always #50 clk = ~clk;

  uhbpi_host_port uhbpi_host_port_inst (.clk, .rst, .clkEn(1'b1), .busStyleSel, .chipSelN,
    .readStrobeN, .writeStrobeN, .registerSelectLines, .hostDataLinesIn, .hostDataLinesOut,
    .hostDataLinesOeN, .irqOut, .irqOeN, .txPin, .rxPin, .regRead, .regWrite, .regAddr,
    .regWrData, .regRdData, .intRequest, .irq_output_enable_bit, .infrared_mode_bit,
    .txSerial, .txActive, .rxSerial);
  uhbpi_reg_model uhbpi_reg_model_inst (.clk, .regWrite, .regAddr, .regWrData, .regRdData);

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic take(input logic [11:0] seen);
    if (q.size() == 0) check(seen, 12'hfff);
    else check(seen, q.pop_front());
  endtask

  task automatic summarize;
    if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // One access; rw-line style also holds the read strobe low to show it is ignored
  task automatic acc(input logic st, wr, cs, input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    busStyleSel <= st;
    registerSelectLines <= a;
    hostDataLinesIn <= d;
    writeStrobeN <= st | !wr;
    repeat (3) @(posedge clk);
    chipSelN <= !cs;
    if (st && wr) writeStrobeN <= 0;
    else readStrobeN <= 0;
    if (cs) q.push_back({!wr, a, wr ? d : shadow[a]});
    if (cs && wr) shadow[a] = d;
    repeat (8) @(posedge clk);
    // Strobe ends while still selected; CS rising first would abort the write
    readStrobeN <= 1;
    if (st) writeStrobeN <= 1;
    repeat (4) @(posedge clk);
    chipSelN <= 1;
    writeStrobeN <= 1;
    repeat (6) @(posedge clk);
  endtask

  always @(posedge clk) begin
    if (!rst) begin
      rnd = 7'($random(seed));
      {intRequest, irq_output_enable_bit, infrared_mode_bit, txSerial, txActive} <= rnd[6:2];
      // Far end idles high in standard mode, low in infrared mode
      rxPin <= rnd[1] ? rnd[0] : !rnd[4];
      if (regRead) rdA <= regAddr;
      if (regWrite) take({1'b0, regAddr, regWrData});
      if (oePrev && !hostDataLinesOeN) take({1'b1, rdA, hostDataLinesOut});
      oePrev <= hostDataLinesOeN;
    end
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      summarize();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    check({11'h0, txPin}, 12'h1);
    rst <= 0;
    for (i = 0; i < 8; i++) acc(1, 1, 1, 3'(i), 8'($random(seed)));
    for (i = 0; i < 8; i++) acc(1, 0, 1, 3'(i), 8'h0);
    acc(1, 1, 0, 3'h2, 8'h5a);
    acc(1, 0, 0, 3'h2, 8'h0);
    for (i = 0; i < 4; i++) begin
      acc(0, 1, 1, 3'(i), 8'($random(seed)));
      acc(0, 0, 1, 3'(i), 8'h0);
    end
    repeat (10) @(posedge clk);
    check({11'h0, q.size() == 0}, 12'h1);
    summarize();
  end
endmodule

`default_nettype wire
